// ### src/amc_pkg.sv
// constants shared by the converter control end and the host sequencer end
// assumes one 250 MHz clock for both ends and a serial port of 24-bit commands
// How it works
// - only rising clock edges drive all timing
// - clock format needs no configuration write
// - reset by pin pulse or 0x0001 at 0x00
// - power-down by pin or 0x0f writes
// - host start-up order: reset, down, phase, mode, up, inputs
// - phase register written only while powered down
// - mode changed only while powered down
// - mode change: down, mode, up, inputs
// - 0x31 selects mode and divider
// - input routing applies when each write completes
// - dual mode: 0x3a channel one, 0x3b two
// - single mode: both registers carry same value
// - quad mode: bytes map channels one to four
package amc_pkg;
    localparam int          CMD_BITS       = 24;
    localparam logic [4:0]  CMD_CNT_LAST   = 5'h17;
    localparam logic [7:0]  ADDR_RESET     = 8'h00;
    localparam logic [7:0]  ADDR_POWER     = 8'h0f;
    localparam logic [7:0]  ADDR_MODE      = 8'h31;
    localparam logic [7:0]  ADDR_SEL_LO    = 8'h3a;
    localparam logic [7:0]  ADDR_SEL_HI    = 8'h3b;
    localparam logic [7:0]  ADDR_PHASE     = 8'h42;
    localparam logic [15:0] VAL_RESET      = 16'h0001;
    localparam logic [15:0] VAL_POWER_DOWN = 16'h0200;
    localparam logic [15:0] VAL_ACTIVE     = 16'h0000;
    localparam logic [15:0] MODE_SINGLE    = 16'h0001;
    localparam logic [15:0] MODE_DUAL      = 16'h0102;
    localparam logic [15:0] MODE_QUAD      = 16'h0204;
    localparam logic [15:0] RST_MODE       = 16'h0001;
    localparam logic [15:0] RST_SEL        = 16'h0202;
    localparam logic [15:0] RST_PHASE      = 16'h0000;
    localparam logic [7:0]  SEL_IN1        = 8'h02;
    localparam logic [7:0]  SEL_IN2        = 8'h04;
    localparam logic [7:0]  SEL_IN3        = 8'h08;
    localparam logic [7:0]  SEL_IN4        = 8'h10;
    typedef enum logic [1:0] {AMC_SINGLE, AMC_DUAL, AMC_QUAD, AMC_BAD} amc_mode_t;
endpackage

// ### src/amc_if.sv
// serial command link and control pins between host and converter control
// assumes both ends share ref_clk; data is shifted msb first
`timescale 1ns/1ns
interface amc_if;
    logic ser_sel;
    logic ser_data;
    logic chip_reset_low_pin;
    logic power_down_pin;
    modport host (output ser_sel, output ser_data, output chip_reset_low_pin,
                  output power_down_pin);
    modport dev  (input ser_sel, input ser_data, input chip_reset_low_pin,
                  input power_down_pin);
endinterface

// ### src/amc_host.sv
// host sequencer: turns one command request into a serial write, holds the pins
// assumes the user orders the writes as the start-up and mode-change sequences ask
`timescale 1ns/1ns
module amc_host (
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic        req_valid,
    input  wire logic [7:0]  req_addr,
    input  wire logic [15:0] req_data,
    input  wire logic        pin_reset_low,
    input  wire logic        pin_power_down,
    output logic             req_ready,
    amc_if.host              link
);
    logic [23:0] shift_r;
    logic [4:0]  cnt_r;
    logic        busy_r;
    logic        ready_r;
    logic        sel_r;
    logic        rst_pin_r;
    logic        pd_pin_r;
    wire         take = req_valid && !busy_r;
    wire         last = busy_r && (cnt_r == amc_pkg::CMD_CNT_LAST);

    // --------------------------------------------------------------
    // command shifter
    // --------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            shift_r <= 24'h000000;
            cnt_r   <= 5'h00;
            busy_r  <= 1'b0;
            ready_r <= 1'b1;
            sel_r   <= 1'b0;
        end else if (take) begin
            shift_r <= {req_addr, req_data};
            cnt_r   <= 5'h00;
            busy_r  <= 1'b1;
            ready_r <= 1'b0;
            sel_r   <= 1'b1;
        end else if (busy_r) begin
            shift_r <= {shift_r[22:0], 1'b0};
            cnt_r   <= cnt_r + 5'h01;
            busy_r  <= !last;
            ready_r <= last;
            sel_r   <= !last;
        end
    end

    // pins registered so outputs come from flip-flops; order kept by user
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rst_pin_r <= 1'b1;
            pd_pin_r  <= 1'b0;
        end else begin
            rst_pin_r <= pin_reset_low;
            pd_pin_r  <= pin_power_down;
        end
    end

    // ready kept as its own flop so the output comes straight from a register
    assign req_ready               = ready_r;
    assign link.ser_sel            = sel_r;
    assign link.ser_data           = shift_r[23];
    assign link.chip_reset_low_pin = rst_pin_r;
    assign link.power_down_pin     = pd_pin_r;
endmodule

// ### src/amc_dev.sv
// converter control end: serial command receiver, register bank, power and routing
// assumes commands arrive msb first, one bit per ref_clk while ser_sel is high
`timescale 1ns/1ns
module amc_dev (
    input  wire logic        ref_clk,
    input  wire logic        srst,
    amc_if.dev               link,
    output logic             powered_down,
    output logic [1:0]       mode,
    output logic [2:0]       clk_div,
    output logic [15:0]      phase_setting,
    output logic [31:0]      route_sel,
    output logic             mode_error
);
    logic [23:0] sh_r;
    logic [4:0]  cnt_r;
    logic [15:0] mode_r;
    logic [15:0] sel_lo_r;
    logic [15:0] sel_hi_r;
    logic [15:0] phase_r;
    logic        soft_pd_r;
    logic        pd_r;
    logic [1:0]  mode_out_r;
    logic [2:0]  div_r;
    logic [31:0] route_r;
    logic        err_r;

    // --------------------------------------------------------------
    // command receive: rising edges only, no clock format setting
    // --------------------------------------------------------------
    wire        bit_in   = link.ser_sel;
    wire [23:0] sh_nxt   = {sh_r[22:0], link.ser_data};
    wire        done     = bit_in && (cnt_r == amc_pkg::CMD_CNT_LAST);
    wire [7:0]  w_addr   = sh_nxt[23:16];
    wire [15:0] w_data   = sh_nxt[15:0];
    wire        pin_rst  = !link.chip_reset_low_pin;
    wire        soft_rst = done && (w_addr == amc_pkg::ADDR_RESET)
                           && (w_data == amc_pkg::VAL_RESET);
    wire        any_rst  = srst || pin_rst || soft_rst;
    wire        down     = soft_pd_r || link.power_down_pin;
    wire        wr_pwr   = done && (w_addr == amc_pkg::ADDR_POWER);
    // mode and phase only taken while down; an active write is flagged
    wire        wr_mode  = done && (w_addr == amc_pkg::ADDR_MODE);
    wire        wr_phase = done && (w_addr == amc_pkg::ADDR_PHASE);

    always_ff @(posedge ref_clk) begin
        if (srst || pin_rst) begin
            sh_r  <= 24'h000000;
            cnt_r <= 5'h00;
        end else if (bit_in) begin
            sh_r  <= sh_nxt;
            cnt_r <= done ? 5'h00 : cnt_r + 5'h01;
        end else begin
            cnt_r <= 5'h00;
        end
    end

    // --------------------------------------------------------------
    // register bank
    // --------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (any_rst) begin
            mode_r    <= amc_pkg::RST_MODE;
            sel_lo_r  <= amc_pkg::RST_SEL;
            sel_hi_r  <= amc_pkg::RST_SEL;
            phase_r   <= amc_pkg::RST_PHASE;
            soft_pd_r <= 1'b0;
            err_r     <= 1'b0;
        end else begin
            if (wr_pwr && w_data == amc_pkg::VAL_POWER_DOWN)
                soft_pd_r <= 1'b1;
            else if (wr_pwr && w_data == amc_pkg::VAL_ACTIVE)
                soft_pd_r <= 1'b0;
            if (wr_mode && down)
                mode_r <= w_data;
            if ((wr_mode || wr_phase) && !down)
                err_r <= 1'b1;
            if (wr_phase && down)
                phase_r <= w_data;
            if (done && w_addr == amc_pkg::ADDR_SEL_LO)
                sel_lo_r <= w_data;
            if (done && w_addr == amc_pkg::ADDR_SEL_HI)
                sel_hi_r <= w_data;
        end
    end

    // --------------------------------------------------------------
    // mode decode and routing
    // --------------------------------------------------------------
    wire amc_pkg::amc_mode_t m_dec =
        (mode_r == amc_pkg::MODE_SINGLE) ? amc_pkg::AMC_SINGLE :
        (mode_r == amc_pkg::MODE_DUAL)   ? amc_pkg::AMC_DUAL   :
        (mode_r == amc_pkg::MODE_QUAD)   ? amc_pkg::AMC_QUAD   : amc_pkg::AMC_BAD;
    wire [2:0] div_dec = (m_dec == amc_pkg::AMC_DUAL) ? 3'h2 :
                         (m_dec == amc_pkg::AMC_QUAD) ? 3'h4 : 3'h1;
    // channel bytes: {ch4, ch3, ch2, ch1}, one-hot input code each
    wire [7:0] ch1 = sel_lo_r[15:8];
    wire [7:0] ch2 = (m_dec == amc_pkg::AMC_QUAD) ? sel_lo_r[7:0] : sel_hi_r[15:8];
    wire [7:0] ch3 = (m_dec == amc_pkg::AMC_QUAD) ? sel_hi_r[15:8] : 8'h00;
    wire [7:0] ch4 = (m_dec == amc_pkg::AMC_QUAD) ? sel_hi_r[7:0] : 8'h00;
    // single mode routes one input; both registers expected equal
    wire [31:0] route_nxt = (m_dec == amc_pkg::AMC_SINGLE) ? {24'h000000, ch1}
                                                           : {ch4, ch3, ch2, ch1};

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pd_r       <= 1'b0;
            mode_out_r <= 2'h0;
            div_r      <= 3'h1;
            route_r    <= 32'h00000000;
        end else begin
            pd_r       <= down;
            mode_out_r <= m_dec;
            div_r      <= div_dec;
            route_r    <= route_nxt;
        end
    end

    assign powered_down  = pd_r;
    assign mode          = mode_out_r;
    assign clk_div       = div_r;
    assign phase_setting = phase_r;
    assign route_sel     = route_r;
    assign mode_error    = err_r;
endmodule

// ### dv/amc_properties.sv
// checker on the serial link and pins between host and converter ends
// assumes it sits beside the interface instance in the bench
`timescale 1ns/1ns
module amc_properties (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic ser_sel,
    input wire logic ser_data,
    input wire logic chip_reset_low_pin,
    input wire logic power_down_pin
);
    // ----
    // frame length counter
    // ----
    logic [4:0] cnt_r;
    always_ff @(posedge ref_clk) begin
        if (srst || !ser_sel) cnt_r <= 5'h00;
        else cnt_r <= cnt_r + 5'h01;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    a_frame_max_len: assert property (ser_sel |-> cnt_r < 5'h18)
        else $error("select held past 24 bits");
    a_frame_full_len: assert property ($fell(ser_sel) |-> $past(cnt_r) == 5'h17)
        else $error("frame ended short of 24 bits");
    a_frame_gap: assert property (ser_sel && cnt_r == 5'h17 |=> !ser_sel)
        else $error("no gap after a frame");
    a_pins_idle_reset: assert property ($past(srst) |-> chip_reset_low_pin && !power_down_pin)
        else $error("pins not idle after reset");
    a_sel_idle_reset: assert property ($past(srst) |-> !ser_sel)
        else $error("select high right after reset");
    a_data_idle_low: assert property (!ser_sel |-> !ser_data)
        else $error("data line active outside a frame");
    c_frame: cover property ($fell(ser_sel));
    c_pin_reset: cover property ($fell(chip_reset_low_pin));
    c_pin_down: cover property ($rose(power_down_pin));
endmodule

// ### dv/adc_mode_input_config_tb.sv
// self-checking bench: host end drives converter end over the link
// assumes one 250 MHz ref_clk for both ends
`timescale 1ns/1ns
module adc_mode_input_config_tb;
    logic        ref_clk, srst, req_valid, req_ready, pin_reset_low, pin_power_down;
    logic        powered_down, mode_error;
    logic [7:0]  req_addr;
    logic [15:0] req_data, phase_setting;
    logic [1:0]  mode;
    logic [2:0]  clk_div;
    logic [31:0] route_sel;
    int          n_mismatch, n_tests;
    amc_if link ();
    amc_host amc_host_i (.ref_clk, .srst, .req_valid, .req_addr, .req_data, .pin_reset_low,
        .pin_power_down, .req_ready, .link(link.host));
    amc_dev amc_dev_i (.ref_clk, .srst, .link(link.dev), .powered_down, .mode, .clk_div,
        .phase_setting, .route_sel, .mode_error);
    amc_properties amc_properties_i (.ref_clk, .srst, .ser_sel(link.ser_sel),
        .ser_data(link.ser_data), .chip_reset_low_pin(link.chip_reset_low_pin),
        .power_down_pin(link.power_down_pin));
    // ----
    // helpers
    // ----
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic send(logic [7:0] a, logic [15:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        req_valid <= 1'b1;
        req_addr <= a;
        req_data <= d;
        // request held until the edge at which ready is seen high
        do @(posedge ref_clk); while (!req_ready);
        req_valid <= 1'b0;
        do begin
            @(posedge ref_clk);
            #1;
            n++;
        end while (!req_ready && n < 40);
        if (n >= 40) chk(32'h0, 32'h1);
        // registered outputs land one edge after the register update; phase_setting and mode_error do not
        repeat (2) @(posedge ref_clk);
        #1;
    endtask
    task automatic pins(logic r, logic p);
        @(posedge ref_clk);
        pin_reset_low <= r;
        pin_power_down <= p;
        repeat (4) @(posedge ref_clk);
        #1;
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // ----
    // scenarios
    // ----
    task automatic t_startup();
        logic [15:0] m[3] = '{16'h0001, 16'h0102, 16'h0204};
        chk({mode, clk_div}, {2'h0, 3'h1});
        chk(route_sel, 32'h2);
        send(8'h0f, 16'h0200);
        chk(powered_down, 1);
        send(8'h42, 16'h0003);
        chk(phase_setting, 16'h0003);
        for (int i = 0; i < 3; i++) begin
            send(8'h31, m[i]);
            chk({mode, clk_div}, {i[1:0], 3'h1 << i});
        end
        send(8'h0f, 16'h0000);
        chk(powered_down, 0);
        $display("done startup");
    endtask
    task automatic t_quad();
        send(8'h3a, 16'h1008);
        chk(route_sel[15:0], 16'h0810);
        send(8'h3b, 16'h0402);
        chk(route_sel, 32'h02040810);
        // mode write while active must be refused
        send(8'h31, 16'h0001);
        chk({mode, mode_error}, {2'h2, 1'b1});
        $display("done quad");
    endtask
    task automatic t_pins();
        pins(1'b1, 1'b1);
        chk(powered_down, 1);
        pins(1'b1, 1'b0);
        chk(powered_down, 0);
        pins(1'b0, 1'b0);
        pins(1'b1, 1'b0);
        chk({mode, mode_error}, 0);
        $display("done pins");
    endtask
    task automatic t_soft();
        send(8'h0f, 16'h0200);
        send(8'h31, 16'h0102);
        chk(mode, 1);
        send(8'h00, 16'h0001);
        chk({mode, powered_down}, 0);
        send(8'h3a, 16'h1010);
        send(8'h3b, 16'h1010);
        chk(route_sel, 32'h10);
        send(8'h0f, 16'h0200);
        send(8'h31, 16'h0102);
        send(8'h0f, 16'h0000);
        send(8'h3a, 16'h0202);
        send(8'h3b, 16'h0808);
        chk(route_sel, 32'h0802);
        send(8'h42, 16'h0005);
        chk({phase_setting, mode_error}, {16'h0000, 1'b1});
        send(8'h0f, 16'h0200);
        send(8'h31, 16'h0003);
        chk({mode, clk_div}, {2'h3, 3'h1});
        $display("done soft");
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    initial begin
        {srst, pin_reset_low, pin_power_down, req_valid} = 4'hc;
        {req_addr, req_data} = 24'h0;
        n_mismatch = 0;
        n_tests = 0;
        repeat (5) @(posedge ref_clk);
        srst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        t_startup();
        t_quad();
        t_pins();
        t_soft();
        wrap_up();
    end
    // about 20 commands of 30 cycles; generous margin
    initial begin
        #40000;
        n_mismatch++;
        wrap_up();
    end
endmodule
